// ==== design/bidir_port_pkg.sv ====
package bidir_port_pkg;
    // Port mode codes for the two bidirectional modes.
    localparam logic [1:0] MODE_BIDIR8 = 2'h2;
    localparam logic [1:0] MODE_BIDIR16 = 2'h3;
    // Synchroniser vector: cs_n, read, sel_b, wdata[8], h1, h3, pa[8], pb[8].
    localparam int SYNC_W = 29;
    localparam logic [28:0] SYNC_RESET = 29'h1000_0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    // Request timing, in device clocks; the port delay is first given in half clocks.
    localparam int BUS_REQ_DELAY_CLK = 3;
    localparam int PORT_REQ_DELAY_HALF_CLK = 5;
    localparam int PORT_REQ_DELAY_CLK = (PORT_REQ_DELAY_HALF_CLK + 1) / 2;
    localparam int REQ_HOLD_CLK = 3;
    // Width of a pulsed handshake on the output pins, in clocks.
    localparam int HS_PULSE_CLK = 4;
    localparam int CNT_W = 3;
    // Only these two handshake options exist on the output pins.
    typedef enum logic {HS_INTERLOCKED, HS_PULSED} hs_opt_t;
endpackage

// ==== design/req_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Triggers from the port logic to the request pulse generator.
interface req_if;
    logic bus_trig;
    logic port_trig;
    logic pulse;
    modport gen (input bus_trig, input port_trig, output pulse);
    modport user (output bus_trig, output port_trig, input pulse);
endinterface
`default_nettype wire

// ==== design/req_pulse_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module req_pulse_gen
    import bidir_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    req_if.gen rq
);
    typedef enum logic [1:0] {RQ_IDLE, RQ_DELAY, RQ_HOLD} rq_state_t;

    rq_state_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic pulse_q;
    logic port_defer_q;
    logic bus_pend_q;
    logic port_pend_q;
    logic port_ev;
    logic start;
    logic start_bus;

    // A strobe that coincides with a bus access is seen one clock later.
    assign port_ev = (rq.port_trig & ~rq.bus_trig) | port_defer_q;
    assign start = (state_q == RQ_IDLE) &
                   (rq.bus_trig | bus_pend_q | port_ev | port_pend_q);
    assign start_bus = rq.bus_trig | bus_pend_q;
    assign rq.pulse = pulse_q;

    // Events that arrive while a pulse runs wait, one per source; an event
    // that starts a pulse at once is not queued again, or it would repeat.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_defer_q <= 1'b0;
            bus_pend_q <= 1'b0;
            port_pend_q <= 1'b0;
        end else begin
            port_defer_q <= rq.port_trig & rq.bus_trig;
            bus_pend_q <= (rq.bus_trig | bus_pend_q) & ~(start & start_bus);
            port_pend_q <= (port_ev & ~(start & ~start_bus)) |
                           (port_pend_q & ~(start & ~start_bus & ~port_ev));
        end
    end

    // Delay then hold; bus and port causes both load the same three-clock delay count.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= RQ_IDLE;
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            unique case (state_q)
                RQ_IDLE: begin
                    if (start) begin
                        state_q <= RQ_DELAY;
                        cnt_q <= start_bus ?
                                 CNT_W'(BUS_REQ_DELAY_CLK - 1) :
                                 CNT_W'(PORT_REQ_DELAY_CLK - 1);
                    end
                end
                RQ_DELAY: begin
                    if (cnt_q == CNT_W'(1)) begin
                        state_q <= RQ_HOLD;
                        pulse_q <= 1'b1;
                        cnt_q <= CNT_W'(REQ_HOLD_CLK - 1);
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
                RQ_HOLD: begin
                    if (cnt_q == '0) begin
                        state_q <= RQ_IDLE;
                        pulse_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    property p_req_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(pulse_q) |-> pulse_q [*3] ##1 !pulse_q;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request pulse not held for three clocks");

    property p_bus_delay;
        @(posedge sys_clk) disable iff (!arst_n)
        (state_q == RQ_IDLE && rq.bus_trig && !bus_pend_q && !port_pend_q
         && !port_defer_q) |-> !pulse_q ##1 !pulse_q ##1 !pulse_q ##1 pulse_q;
    endproperty
    a_bus_delay: assert property (p_bus_delay)
        else $error("bus request not raised three clocks after access");

    property p_port_delay;
        @(posedge sys_clk) disable iff (!arst_n)
        (state_q == RQ_IDLE && port_ev && !rq.bus_trig && !bus_pend_q)
        |-> ##3 $rose(pulse_q);
    endproperty
    a_port_delay: assert property (p_port_delay)
        else $error("port request not raised three clocks after strobe");

    property p_defer;
        @(posedge sys_clk) disable iff (!arst_n)
        (rq.bus_trig && rq.port_trig) |=> port_ev;
    endproperty
    a_defer: assert property (p_defer)
        else $error("coincident strobe not seen one clock later");
endmodule
`default_nettype wire

// ==== design/bidir_handshake_port.sv ====
// What this block does
// - 8-bit bidir: all port B drivers on only while output accept is negated.
// - 16-bit bidir: all 16 drivers on only while output accept is negated.
// - Output handshake pins offer only interlocked and pulsed options.
// - Request pulse serves input strobes or output accepts, never both.
// - 8-bit bidir: port A is single-buffered bit I/O, driven where dir is 1.
// - 8-bit bidir: port A read gives pin where dir 0, latch where dir 1.
// - 16-bit bidir: one 16-bit port, output and input pairs each enabled.
// - 16-bit bidir: direction follows output accept only, dir bits ignored.
// - 16-bit bidir: all pins captured on input strobe asserted edge.
// - Output accept is also edge-sensitive for handshake and status.
// - Valid reports new output latch data; pins driven only while enabled.
// - 16-bit bidir: handshakes advance on port B accesses only.
// - Enabled request keeps output latches full or input latches empty.
// - Bus request: asserted 3 clocks after synchronized select, held 3.
// - Port request: asserted 3 clocks (2.5 rounded up) after synchronized strobe, held 3.
// - Coincident access and strobe: select at once, strobe a clock later.
// - Mode field code 2 selects 8-bit bidir, code 3 selects 16-bit bidir.
// - 8-bit bidir ignores port B direction bits and submode fields.
`timescale 1ns/1ps
`default_nettype none
module bidir_handshake_port
    import bidir_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [1:0] port_mode,
    input wire logic out_pair_enable,
    input wire logic in_pair_enable,
    input wire hs_opt_t out_hs_opt,
    input wire hs_opt_t in_hs_opt,
    input wire logic [7:0] port_a_dir,
    input wire logic req_enable,
    input wire logic req_for_input,
    input wire logic status_clear,
    output logic accept_seen,
    output logic in_data_ready,
    output logic out_room,
    input wire logic bus_cs_n,
    input wire logic bus_read,
    input wire logic bus_sel_b,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    input wire logic out_accept_strobe,
    input wire logic in_latch_strobe,
    output logic out_data_valid,
    output logic in_handshake_out,
    output logic transfer_request_pulse,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe
);
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [SYNC_W-1:0] sync_in;
    logic cs_n_s;
    logic read_s;
    logic sel_b_s;
    logic [7:0] wdata_s;
    logic h1_s;
    logic h3_s;
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic cs_prev_q;
    logic h1_prev_q;
    logic h3_prev_q;
    logic mode8;
    logic mode16;
    logic bidir;
    logic access;
    logic a_wr;
    logic b_wr;
    logic a_rd;
    logic b_rd;
    logic h1_ev;
    logic h3_ev;
    logic [7:0] temp_a_q;
    logic [7:0] pa_latch_q;
    logic [15:0] out_word;
    logic [15:0] iol_q;
    logic [15:0] iol_d;
    logic iol_full_q;
    logic iol_full_d;
    logic [15:0] fol_q;
    logic [15:0] fol_d;
    logic fol_full_q;
    logic fol_full_d;
    logic fol_take;
    logic fol_load;
    logic [15:0] iil_q;
    logic [15:0] iil_d;
    logic iil_full_q;
    logic iil_full_d;
    logic [15:0] fil_q;
    logic [15:0] fil_d;
    logic fil_full_q;
    logic fil_full_d;
    logic cap_ok;
    logic fil_free;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] pa_read;
    logic odv_q;
    logic odv_d;
    logic [CNT_W-1:0] odv_cnt_q;
    logic [CNT_W-1:0] odv_cnt_d;
    logic ihs_q;
    logic ihs_d;
    logic [CNT_W-1:0] ihs_cnt_q;
    logic [CNT_W-1:0] ihs_cnt_d;
    logic seen_q;

    req_if rq ();

    // Every pin input passes two flops before anything looks at it.
    assign sync_in = {bus_cs_n, bus_read, bus_sel_b, bus_wdata,
                      out_accept_strobe, in_latch_strobe, pa_in, pb_in};
    assign {cs_n_s, read_s, sel_b_s, wdata_s, h1_s, h3_s, pa_s, pb_s} =
        sync2_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
            cs_prev_q <= 1'b1;
            h1_prev_q <= 1'b0;
            h3_prev_q <= 1'b0;
        end else begin
            sync1_q <= sync_in;
            sync2_q <= sync1_q;
            cs_prev_q <= cs_n_s;
            h1_prev_q <= h1_s;
            h3_prev_q <= h3_s;
        end
    end

    // Mode and access decode. One access per select assertion, taken at
    // the synchronised falling edge; address and data are stable by then.
    assign mode8 = (port_mode == MODE_BIDIR8);
    assign mode16 = (port_mode == MODE_BIDIR16);
    assign bidir = mode8 | mode16;
    assign access = cs_prev_q & ~cs_n_s & bidir;
    assign a_wr = access & ~read_s & ~sel_b_s;
    assign b_wr = access & ~read_s & sel_b_s;
    assign a_rd = access & read_s & ~sel_b_s;
    assign b_rd = access & read_s & sel_b_s;

    // Handshake edges, each gated by its own pair enable.
    assign h1_ev = h1_s & ~h1_prev_q & out_pair_enable & bidir;
    assign h3_ev = h3_s & ~h3_prev_q & in_pair_enable & bidir;

    // Drivers follow the accept level only; port B direction bits do not
    // exist here, and port A direction bits matter only in the 8-bit mode.
    assign pb_oe = {8{bidir & ~h1_s}};
    assign pa_oe = mode16 ? {8{~h1_s}} :
                   mode8 ? port_a_dir : BYTE_RESET;
    assign pb_out = fol_q[7:0];
    assign pa_out = mode16 ? fol_q[15:8] : pa_latch_q;

    // Port A writes: temporary high byte in 16-bit mode, plain latch in
    // 8-bit mode. Neither touches a handshake.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            temp_a_q <= BYTE_RESET;
            pa_latch_q <= BYTE_RESET;
        end else if (a_wr) begin
            if (mode16) begin
                temp_a_q <= wdata_s;
            end else begin
                pa_latch_q <= wdata_s;
            end
        end
    end

    // Output double buffer. A port B write moves the whole word; the
    // accept edge empties the final latch and pulls the initial one up.
    // A write with both latches full is dropped, so pace writes by out_room.
    assign out_word = {temp_a_q, wdata_s};
    assign fol_take = h1_ev & fol_full_q;

    always_comb begin
        fol_d = fol_q;
        fol_full_d = fol_full_q;
        iol_d = iol_q;
        iol_full_d = iol_full_q;
        fol_load = 1'b0;
        if (fol_take) begin
            if (iol_full_q) begin
                fol_d = iol_q;
                fol_load = 1'b1;
                iol_full_d = b_wr;
                if (b_wr) begin
                    iol_d = out_word;
                end
            end else if (b_wr) begin
                fol_d = out_word;
                fol_load = 1'b1;
            end else begin
                fol_full_d = 1'b0;
            end
        end else if (b_wr) begin
            if (!fol_full_q) begin
                fol_d = out_word;
                fol_full_d = 1'b1;
                fol_load = 1'b1;
            end else if (!iol_full_q) begin
                iol_d = out_word;
                iol_full_d = 1'b1;
            end
        end
    end

    // Input double buffer. The strobe edge captures every pin; a port B
    // read empties the final latch. Port A reads only peek at the high byte.
    assign cap_ok = h3_ev & ~(fil_full_q & iil_full_q);
    assign fil_free = b_rd & fil_full_q;

    always_comb begin
        fil_d = fil_q;
        fil_full_d = fil_full_q;
        iil_d = iil_q;
        iil_full_d = iil_full_q;
        if (fil_free) begin
            fil_full_d = iil_full_q | h3_ev;
            iil_full_d = iil_full_q & h3_ev;
            if (iil_full_q) begin
                fil_d = iil_q;
                if (h3_ev) begin
                    iil_d = {pa_s, pb_s};
                end
            end else if (h3_ev) begin
                fil_d = {pa_s, pb_s};
            end
        end else if (h3_ev) begin
            if (!fil_full_q) begin
                fil_d = {pa_s, pb_s};
                fil_full_d = 1'b1;
            end else if (!iil_full_q) begin
                iil_d = {pa_s, pb_s};
                iil_full_d = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            iol_q <= WORD_RESET;
            iol_full_q <= 1'b0;
            fol_q <= WORD_RESET;
            fol_full_q <= 1'b0;
            iil_q <= WORD_RESET;
            iil_full_q <= 1'b0;
            fil_q <= WORD_RESET;
            fil_full_q <= 1'b0;
        end else begin
            iol_q <= iol_d;
            iol_full_q <= iol_full_d;
            fol_q <= fol_d;
            fol_full_q <= fol_full_d;
            iil_q <= iil_d;
            iil_full_q <= iil_full_d;
            fil_q <= fil_d;
            fil_full_q <= fil_full_d;
        end
    end

    // Read data: in 8-bit mode port A shows pins for inputs and the latch for outputs.
    assign pa_read = mode16 ? fil_q[15:8] :
                     (pa_s & ~port_a_dir) | (pa_latch_q & port_a_dir);
    assign rdata_d = sel_b_s ? fil_q[7:0] : pa_read;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= BYTE_RESET;
        end else if (a_rd | b_rd) begin
            rdata_q <= rdata_d;
        end
    end

    // Output valid: interlocked follows a full final latch and drops for a
    // clock on each accept; pulsed marks each new word for a few clocks.
    always_comb begin
        odv_cnt_d = odv_cnt_q;
        if (out_hs_opt == HS_INTERLOCKED) begin
            odv_d = out_pair_enable & fol_full_d & ~fol_take;
            odv_cnt_d = '0;
        end else if (fol_load & out_pair_enable) begin
            odv_d = 1'b1;
            odv_cnt_d = CNT_W'(HS_PULSE_CLK - 1);
        end else if (odv_cnt_q != '0 && !h1_ev) begin
            odv_d = 1'b1;
            odv_cnt_d = odv_cnt_q - CNT_W'(1);
        end else begin
            odv_d = 1'b0;
            odv_cnt_d = '0;
        end
    end

    // Input handshake: interlocked shows room in the latches; pulsed
    // acknowledges each strobe that finds a latch empty.
    always_comb begin
        ihs_cnt_d = ihs_cnt_q;
        if (in_hs_opt == HS_INTERLOCKED) begin
            ihs_d = in_pair_enable & bidir & ~iil_full_d;
            ihs_cnt_d = '0;
        end else if (cap_ok) begin
            ihs_d = 1'b1;
            ihs_cnt_d = CNT_W'(HS_PULSE_CLK - 1);
        end else if (ihs_cnt_q != '0) begin
            ihs_d = 1'b1;
            ihs_cnt_d = ihs_cnt_q - CNT_W'(1);
        end else begin
            ihs_d = 1'b0;
            ihs_cnt_d = '0;
        end
    end

    // Accept status sets on each accept edge; the set beats a clear.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            odv_q <= 1'b0;
            odv_cnt_q <= '0;
            ihs_q <= 1'b0;
            ihs_cnt_q <= '0;
            seen_q <= 1'b0;
        end else begin
            odv_q <= odv_d;
            odv_cnt_q <= odv_cnt_d;
            ihs_q <= ihs_d;
            ihs_cnt_q <= ihs_cnt_d;
            seen_q <= h1_ev | (seen_q & ~status_clear & out_pair_enable);
        end
    end

    assign out_data_valid = odv_q;
    assign in_handshake_out = ihs_q;
    assign accept_seen = seen_q;
    assign in_data_ready = fil_full_q;
    assign out_room = ~iol_full_q;
    assign bus_rdata = rdata_q;

    // The request serves one direction only, chosen by req_for_input.
    assign rq.bus_trig = req_enable &
                         (req_for_input ? b_rd : b_wr);
    assign rq.port_trig = req_enable &
                          (req_for_input ? h3_ev : h1_ev);
    assign transfer_request_pulse = rq.pulse;

    req_pulse_gen u_req (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .rq(rq.gen)
    );

    property p_b_off8;
        @(posedge sys_clk) disable iff (!arst_n)
        (mode8 && h1_s) |-> (pb_oe == 8'h00 && pa_oe == port_a_dir);
    endproperty
    a_b_off8: assert property (p_b_off8)
        else $error("port B driven while accept asserted");

    property p_all_on16;
        @(posedge sys_clk) disable iff (!arst_n)
        (mode16 && !h1_s) |-> (pa_oe == 8'hFF && pb_oe == 8'hFF);
    endproperty
    a_all_on16: assert property (p_all_on16)
        else $error("16-bit drivers not all on with accept negated");

    property p_valid_rise;
        @(posedge sys_clk) disable iff (!arst_n)
        ($rose(fol_full_q) && out_hs_opt == HS_INTERLOCKED && out_pair_enable)
        |-> out_data_valid;
    endproperty
    a_valid_rise: assert property (p_valid_rise)
        else $error("valid not raised with new output data");

    property p_capture;
        @(posedge sys_clk) disable iff (!arst_n)
        (mode16 && h3_ev && !fil_full_q)
        |=> fil_q == {$past(pa_s), $past(pb_s)};
    endproperty
    a_capture: assert property (p_capture)
        else $error("pins not captured on input strobe edge");

    property p_a_read_keeps;
        @(posedge sys_clk) disable iff (!arst_n)
        (mode16 && a_rd && !h3_ev) |=> fil_full_q == $past(fil_full_q);
    endproperty
    a_a_read_keeps: assert property (p_a_read_keeps)
        else $error("port A read advanced the input handshake");

    property p_accept_take;
        @(posedge sys_clk) disable iff (!arst_n)
        (h1_ev && fol_full_q && !iol_full_q && !b_wr) |=> !fol_full_q;
    endproperty
    a_accept_take: assert property (p_accept_take)
        else $error("accept edge did not empty the final output latch");

    property p_pa_read8;
        @(posedge sys_clk) disable iff (!arst_n)
        (mode8 && a_rd) |=> (bus_rdata & port_a_dir) == (pa_latch_q & port_a_dir);
    endproperty
    a_pa_read8: assert property (p_pa_read8)
        else $error("port A output bits not read from latch");
endmodule
`default_nettype wire

// ==== test/periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Peripheral on the far side of the handshake pins and both data ports.
module periph_model (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic out_data_valid,
    input wire logic [7:0] pa_pin,
    input wire logic [7:0] pb_pin,
    output logic out_accept_strobe,
    output logic in_latch_strobe,
    output logic [7:0] drv_a,
    output logic [7:0] drv_b,
    output logic [15:0] got,
    output logic [7:0] taken
);
    initial begin
        out_accept_strobe = 1'b1;
        in_latch_strobe = 1'b0;
        drv_a = 8'h3C;
        drv_b = 8'hC3;
        got = 16'h0000;
        taken = 8'h00;
    end
    // Accept idles asserted so the port drivers stay off between words.
    always begin
        wait (out_data_valid === 1'b1);
        @(posedge sys_clk);
        repeat (slow ? 5 : 1) @(posedge sys_clk);
        out_accept_strobe <= 1'b0;
        repeat (5) @(posedge sys_clk);
        got <= {pa_pin, pb_pin};
        out_accept_strobe <= 1'b1;
        taken <= taken + 8'h01;
        repeat (8) @(posedge sys_clk);
    end
    // Lines are inverted once the hold runs out, so stale data never helps.
    task automatic send(input logic [15:0] w);
        @(posedge sys_clk);
        drv_a <= w[15:8];
        drv_b <= w[7:0];
        repeat (3) @(posedge sys_clk);
        in_latch_strobe <= 1'b1;
        repeat (3) @(posedge sys_clk);
        in_latch_strobe <= 1'b0;
        repeat (3) @(posedge sys_clk);
        drv_a <= ~w[15:8];
        drv_b <= ~w[7:0];
    endtask
endmodule
`default_nettype wire

// ==== test/tb_bidir_handshake_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_bidir_handshake_port
    import bidir_port_pkg::*;
;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] port_mode = 2'h0;
    logic out_pair_enable = 1'b0;
    logic in_pair_enable = 1'b0;
    hs_opt_t out_hs_opt = HS_INTERLOCKED;
    hs_opt_t in_hs_opt = HS_INTERLOCKED;
    logic [7:0] port_a_dir = 8'h00;
    logic req_enable = 1'b0;
    logic req_for_input = 1'b0;
    logic status_clear = 1'b0;
    logic bus_cs_n = 1'b1;
    logic bus_read = 1'b0;
    logic bus_sel_b = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic slow = 1'b0;
    logic accept_seen, in_data_ready, out_room, out_accept_strobe;
    logic in_latch_strobe, out_data_valid, in_handshake_out;
    logic transfer_request_pulse;
    logic [7:0] bus_rdata, pa_out, pa_oe, pb_out, pb_oe, drv_a, drv_b;
    logic [7:0] pa_pin, pb_pin, taken, rd;
    logic [15:0] got;
    int err_count = 0;
    int checks_done = 0;
    int req_cycles = 0;

    always #2.5 sys_clk = ~sys_clk;
    // Each pin carries whichever side has its driver on.
    assign pa_pin = (pa_out & pa_oe) | (drv_a & ~pa_oe);
    assign pb_pin = (pb_out & pb_oe) | (drv_b & ~pb_oe);
    // Counts request cycles so that pulse widths and sources can be judged.
    always @(posedge sys_clk) begin
        if (transfer_request_pulse === 1'b1) begin
            req_cycles <= req_cycles + 1;
        end
    end

    bidir_handshake_port u_bidir_handshake_port (.sys_clk(sys_clk),
        .arst_n(arst_n), .port_mode(port_mode),
        .out_pair_enable(out_pair_enable), .in_pair_enable(in_pair_enable),
        .out_hs_opt(out_hs_opt), .in_hs_opt(in_hs_opt),
        .port_a_dir(port_a_dir), .req_enable(req_enable),
        .req_for_input(req_for_input), .status_clear(status_clear),
        .accept_seen(accept_seen), .in_data_ready(in_data_ready),
        .out_room(out_room), .bus_cs_n(bus_cs_n), .bus_read(bus_read),
        .bus_sel_b(bus_sel_b), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .out_accept_strobe(out_accept_strobe),
        .in_latch_strobe(in_latch_strobe), .out_data_valid(out_data_valid),
        .in_handshake_out(in_handshake_out),
        .transfer_request_pulse(transfer_request_pulse), .pa_in(pa_pin),
        .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_pin), .pb_out(pb_out),
        .pb_oe(pb_oe));
    periph_model u_periph_model (.sys_clk(sys_clk), .slow(slow),
        .out_data_valid(out_data_valid), .pa_pin(pa_pin), .pb_pin(pb_pin),
        .out_accept_strobe(out_accept_strobe),
        .in_latch_strobe(in_latch_strobe), .drv_a(drv_a), .drv_b(drv_b),
        .got(got), .taken(taken));

    task automatic conclude();
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Select is held well past the read data edge, then left high.
    task automatic bus(input logic r, input logic b, input logic [7:0] w);
        @(posedge sys_clk);
        bus_cs_n <= 1'b0;
        bus_read <= r;
        bus_sel_b <= b;
        bus_wdata <= w;
        repeat (6) @(posedge sys_clk);
        rd = bus_rdata;
        bus_cs_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
    // Mode is changed only while both pairs are disabled.
    task automatic set_mode(input logic [1:0] m);
        @(posedge sys_clk);
        out_pair_enable <= 1'b0;
        in_pair_enable <= 1'b0;
        port_mode <= m;
        @(posedge sys_clk);
        out_pair_enable <= 1'b1;
        in_pair_enable <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic do_out(input logic [15:0] w, input logic wide, int nreq);
        int r0;
        logic [7:0] n;
        r0 = req_cycles;
        n = taken;
        if (wide) bus(1'b0, 1'b0, w[15:8]);
        bus(1'b0, 1'b1, w[7:0]);
        repeat (100) if (taken === n) @(posedge sys_clk);
        repeat (12) @(posedge sys_clk);
        chk(wide ? got : {8'h00, got[7:0]}, wide ? w : {8'h00, w[7:0]});
        chk({8'h00, pb_oe}, 16'h0000);
        chk({15'h0000, out_data_valid}, 16'h0000);
        chk(16'(req_cycles - r0), 16'(nreq));
        chk({15'h0000, accept_seen}, 16'h0001);
        status_clear <= 1'b1;
        @(posedge sys_clk);
        status_clear <= 1'b0;
        @(posedge sys_clk);
        chk({14'h0000, accept_seen, out_room}, 16'h0001);
    endtask
    task automatic do_in(input logic [15:0] w, input logic wide);
        int r0;
        r0 = req_cycles;
        u_periph_model.send(w);
        repeat (4) @(posedge sys_clk);
        chk({15'h0000, in_data_ready}, 16'h0001);
        chk({15'h0000, in_handshake_out},
            {15'h0000, in_hs_opt == HS_INTERLOCKED});
        if (wide) begin
            bus(1'b1, 1'b0, 8'h00);
            chk({8'h00, rd}, {8'h00, w[15:8]});
            chk({15'h0000, in_data_ready}, 16'h0001);
        end
        bus(1'b1, 1'b1, 8'h00);
        chk({8'h00, rd}, {8'h00, w[7:0]});
        repeat (6) @(posedge sys_clk);
        chk({15'h0000, in_data_ready}, 16'h0000);
        chk(16'(req_cycles - r0), 16'h0006);
    endtask
    task automatic s_bitio();
        port_a_dir <= 8'hF0;
        set_mode(MODE_BIDIR8);
        bus(1'b0, 1'b0, 8'h5A);
        chk({pa_oe, pb_oe}, 16'hF000);
        chk({8'h00, pa_out & pa_oe}, 16'h0050);
        chk({15'h0000, out_data_valid}, 16'h0000);
        bus(1'b1, 1'b0, 8'h00);
        chk({8'h00, rd}, 16'h005C);
    endtask
    task automatic s_out8();
        req_enable <= 1'b1;
        do_out(16'h00A5, 1'b0, 6);
        slow <= 1'b1;
        req_for_input <= 1'b1;
        do_out(16'h00C3, 1'b0, 0);
    endtask
    task automatic s_in8();
        do_in(16'h0096, 1'b0);
    endtask
    task automatic s_out16();
        port_a_dir <= 8'h00;
        set_mode(MODE_BIDIR16);
        slow <= 1'b0;
        req_for_input <= 1'b0;
        out_hs_opt <= HS_PULSED;
        do_out(16'hBE7A, 1'b1, 6);
    endtask
    task automatic s_in16();
        req_for_input <= 1'b1;
        in_hs_opt <= HS_PULSED;
        do_in(16'h1DC8, 1'b1);
    endtask
    // A port B read and a strobe edge land together; both requests follow.
    task automatic s_both();
        int r0;
        r0 = req_cycles;
        fork
            u_periph_model.send(16'h6E21);
            begin
                repeat (3) @(posedge sys_clk);
                bus(1'b1, 1'b1, 8'h00);
            end
        join
        repeat (8) @(posedge sys_clk);
        chk(16'(req_cycles - r0), 16'h0006);
        bus(1'b1, 1'b1, 8'h00);
        chk({8'h00, rd}, 16'h0021);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk({8'h00, pb_oe}, 16'h0000);
        bus(1'b0, 1'b1, 8'hFF);
        s_bitio();
        s_out8();
        s_in8();
        s_out16();
        s_in16();
        s_both();
        conclude();
    end
    // A hang stops here; the whole run needs well under this span.
    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
